// file: src/sdip_pkg.sv
// Shared constants and types of the serial converter input port.
package sdip_pkg;

  // ****************************************************************
  // Word format and codes
  // ****************************************************************
  // Width of the serial word, the holding register and the output latch.
  localparam int WORD_W = 16;
  // Mid-scale is code zero in two's complement; 7fff is full positive and 8000 full negative.
  localparam logic [WORD_W-1:0] CODE_MID = 16'h0000;
  localparam logic [WORD_W-1:0] CODE_POS_FULL = 16'h7fff;
  localparam logic [WORD_W-1:0] CODE_NEG_FULL = 16'h8000;
  // Reset value of the shift and holding registers.
  localparam logic [WORD_W-1:0] SHIFT_RST = 16'h0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // System clock period and the power-on settle time, both in ns.
  localparam int CLK_PERIOD_NS = 25;
  localparam int POR_TIME_NS = 30000;
  localparam int POR_CNT_W = 11;
  // Least time, so the cycle count rounds up.
  localparam logic [POR_CNT_W-1:0] POR_CYCLES =
    POR_CNT_W'((POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Control pin layout of the synchronised pin vector
  // ****************************************************************
  localparam int PIN_W = 5;
  localparam int PIN_BYPASS_N = 0;
  localparam int PIN_MUTE_N = 1;
  localparam int PIN_FRST_N = 2;
  localparam int PIN_OSR_LO = 3;
  localparam int PIN_OSR_HI = 4;
  // Pins read as all low during reset, which mutes the output to mid-scale.
  localparam logic [PIN_W-1:0] PIN_SYNC_RST = 5'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Filter states: disabled, bypassed into the latch, interpolating.
  typedef enum logic [1:0] {MODE_OFF, MODE_BYPASS, MODE_INTERP} sdip_mode_e;

  // Transfer sequencer: waiting for a frame, or one edge after the sync fell.
  typedef enum logic {XF_IDLE, XF_PEND} sdip_xfer_e;

  // Word handed to the interpolation filter, with its oversampling select.
  typedef struct packed {
    logic [WORD_W-1:0] code;
    logic [1:0] osr;
  } sdip_word_s;

endpackage

// file: src/sdip_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sdip_buf2 (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire sdip_pkg::sdip_word_s in_word,
  output logic out_valid,
  input wire logic out_ready,
  output sdip_pkg::sdip_word_s out_word
);

  // ****************************************************************
  // Storage: an output stage and a skid stage, both flip-flops
  // ****************************************************************
  logic out_v_r;
  logic skid_v_r;
  sdip_pkg::sdip_word_s out_d_r;
  sdip_pkg::sdip_word_s skid_d_r;
  logic push;
  logic pop;

  // Ready falls only when both entries hold words, so full is honest.
  assign in_ready = ~skid_v_r;
  assign push = in_valid & ~skid_v_r;
  assign pop = out_v_r & out_ready;
  assign out_valid = out_v_r;
  assign out_word = out_d_r;

  // The skid entry drains first so words leave in arrival order.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_v_r <= 1'b0;
      skid_v_r <= 1'b0;
      out_d_r <= '0;
      skid_d_r <= '0;
    end else if (!out_v_r || pop) begin
      if (skid_v_r) begin
        out_d_r <= skid_d_r;
        out_v_r <= 1'b1;
        skid_v_r <= 1'b0;
      end else begin
        out_v_r <= push;
        if (push) begin
          out_d_r <= in_word;
        end
      end
    end else if (push) begin
      skid_v_r <= 1'b1;
      skid_d_r <= in_word;
    end
  end

endmodule

// file: src/sdip_top.sv
// Serial input port of a 16-bit converter: shift, hold, latch and filter hand-off.
`timescale 1ns/1ps
module sdip_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic serial_data_in,
  input wire logic word_sync,
  input wire logic filter_bypass_n,
  input wire logic output_mute_n,
  input wire logic filter_reset_n,
  input wire logic [1:0] osr_sel,
  input wire logic filt_ready,
  output logic [sdip_pkg::WORD_W-1:0] dac_code,
  output sdip_pkg::sdip_mode_e filter_mode,
  output logic overrun,
  output logic por_done,
  output logic filt_valid,
  output sdip_pkg::sdip_word_s filt_word
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Link domain.
  logic lrst_m_r;
  logic lrst_r;
  logic [sdip_pkg::PIN_W-1:0] pin_m_r;
  logic [sdip_pkg::PIN_W-1:0] pin_s_r;
  logic por_m_r;
  logic por_l_r;
  logic ack_m_r;
  logic ack_s_r;
  logic ws_prev_r;
  logic [sdip_pkg::WORD_W-1:0] shift_r;
  logic [sdip_pkg::WORD_W-1:0] hold_r;
  logic [sdip_pkg::WORD_W-1:0] latch_r;
  sdip_pkg::sdip_xfer_e xf_state_r;
  sdip_pkg::sdip_mode_e mode_r;
  sdip_pkg::sdip_mode_e mode_nxt;
  logic mute_r;
  logic [1:0] osr_r;
  logic req_tgl_r;
  sdip_pkg::sdip_word_s xfer_word_r;
  logic overrun_r;
  logic sync_fall;
  logic link_busy;
  logic xfer_now;
  // System domain.
  logic [sdip_pkg::POR_CNT_W-1:0] por_cnt_r;
  logic por_done_r;
  logic req_m_r;
  logic req_s_r;
  logic ack_tgl_r;
  logic sys_pend;
  logic buf_in_ready;

  // ****************************************************************
  // Link-domain reset and pin synchronisers
  // ****************************************************************
  // The system reset reaches the link logic through two flops; the link
  // clock must run for a few edges while srst is high for this to land.
  always_ff @(posedge link_clk) begin
    lrst_m_r <= srst;
    lrst_r <= lrst_m_r;
  end

  // Control pins are asynchronous to the bit clock, so they pass two flops.
  // The bypass pin is thus seen two bit clocks late; a trade for metastability safety.
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      pin_m_r <= sdip_pkg::PIN_SYNC_RST;
      pin_s_r <= sdip_pkg::PIN_SYNC_RST;
    end else begin
      pin_m_r <= {osr_sel, filter_reset_n, output_mute_n, filter_bypass_n};
      pin_s_r <= pin_m_r;
    end
  end

  // Power-on completion and the hand-off acknowledge cross from the system clock.
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      por_m_r <= 1'b0;
      por_l_r <= 1'b0;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end else begin
      por_m_r <= por_done_r;
      por_l_r <= por_m_r;
      ack_m_r <= ack_tgl_r;
      ack_s_r <= ack_m_r;
    end
  end

  // ****************************************************************
  // Filter state decode
  // ****************************************************************
  // Filter reset low disables the filter outright; otherwise bypass low
  // steers words straight to the latch while the filter keeps running.
  always_comb begin
    if (!pin_s_r[sdip_pkg::PIN_FRST_N]) begin
      mode_nxt = sdip_pkg::MODE_OFF;
    end else if (!pin_s_r[sdip_pkg::PIN_BYPASS_N]) begin
      mode_nxt = sdip_pkg::MODE_BYPASS;
    end else begin
      mode_nxt = sdip_pkg::MODE_INTERP;
    end
  end

  // Mode, mute and rate are registered once so a transfer sees one setting.
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      mode_r <= sdip_pkg::MODE_OFF;
      mute_r <= 1'b1;
      osr_r <= 2'h0;
    end else begin
      mode_r <= mode_nxt;
      mute_r <= ~pin_s_r[sdip_pkg::PIN_MUTE_N];
      osr_r <= pin_s_r[sdip_pkg::PIN_OSR_HI:sdip_pkg::PIN_OSR_LO];
    end
  end

  // ****************************************************************
  // Shift register and word capture
  // ****************************************************************
  // The word sync is timed to the bit clock, so it is sampled directly.
  assign sync_fall = ws_prev_r & ~word_sync;

  // Shifting never pauses; the earliest bit ends in the top position.
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      shift_r <= sdip_pkg::SHIFT_RST;
      ws_prev_r <= 1'b0;
    end else begin
      shift_r <= {shift_r[sdip_pkg::WORD_W-2:0], serial_data_in};
      ws_prev_r <= word_sync;
    end
  end

  // The edge that first sees sync low also shifts the next word's first bit,
  // so the capture takes the register as it stood before that edge.
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      hold_r <= sdip_pkg::SHIFT_RST;
    end else if (sync_fall) begin
      hold_r <= shift_r;
    end
  end

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  // First rise after the fall captures, the second transfers.
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      xf_state_r <= sdip_pkg::XF_IDLE;
    end else begin
      unique case (xf_state_r)
        sdip_pkg::XF_IDLE: begin
          if (sync_fall) begin
            xf_state_r <= sdip_pkg::XF_PEND;
          end
        end
        sdip_pkg::XF_PEND: begin
          xf_state_r <= sdip_pkg::XF_IDLE;
        end
      endcase
    end
  end

  assign xfer_now = (xf_state_r == sdip_pkg::XF_PEND);

  // The latch is written only on a transfer edge; mute wins over every
  // mode, and until power-on settles it sits at mid-scale. In interpolation
  // mode the filter, not this port, drives new points, so the latch holds.
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      latch_r <= sdip_pkg::CODE_MID;
    end else if (!por_l_r) begin
      latch_r <= sdip_pkg::CODE_MID;
    end else if (xfer_now) begin
      if (mute_r) begin
        latch_r <= sdip_pkg::CODE_MID;
      end else if (mode_r != sdip_pkg::MODE_INTERP) begin
        latch_r <= hold_r;
      end
    end
  end

  // ****************************************************************
  // Hand-off to the interpolation filter (toggle handshake)
  // ****************************************************************
  // Hold the word steady while the request is outstanding; a word due
  // during that time is dropped and flagged, since the host cannot stall.
  assign link_busy = (req_tgl_r != ack_s_r);

  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      req_tgl_r <= 1'b0;
      xfer_word_r <= '0;
      overrun_r <= 1'b0;
    end else if (xfer_now && mode_r != sdip_pkg::MODE_OFF) begin
      if (link_busy) begin
        overrun_r <= 1'b1;
      end else begin
        xfer_word_r <= '{code: hold_r, osr: osr_r};
        req_tgl_r <= ~req_tgl_r;
      end
    end
  end

  assign dac_code = latch_r;
  assign filter_mode = mode_r;
  assign overrun = overrun_r;

  // ****************************************************************
  // System domain: power-on timer and word receive
  // ****************************************************************
  // Counts the settle time after reset; the output stays at mid-scale until done.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      por_cnt_r <= '0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      if (por_cnt_r == sdip_pkg::POR_CYCLES - 1'b1) begin
        por_done_r <= 1'b1;
      end
      por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  // The request toggle passes two flops before comparison.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
    end else begin
      req_m_r <= req_tgl_r;
      req_s_r <= req_m_r;
    end
  end

  // A pending word is taken only when the buffer has room, so buffer
  // back-pressure stalls the acknowledge and the link sees it as busy.
  assign sys_pend = (req_s_r != ack_tgl_r);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_tgl_r <= 1'b0;
    end else if (sys_pend && buf_in_ready) begin
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  // Link word register is stable while pending, so it is safe to read here.
  sdip_buf2 u_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(sys_pend),
    .in_ready(buf_in_ready),
    .in_word(xfer_word_r),
    .out_valid(filt_valid),
    .out_ready(filt_ready),
    .out_word(filt_word)
  );

  assign por_done = por_done_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  shift_msb_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    !$past(lrst_r) |-> shift_r[0] == $past(serial_data_in)
      && shift_r[sdip_pkg::WORD_W-1] == $past(shift_r[sdip_pkg::WORD_W-2]))
    else $error("shift register did not take the serial bit");

  hold_capture_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    sync_fall |=> hold_r == $past(shift_r))
    else $error("holding register missed the word at sync fall");

  hold_keep_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    !sync_fall |=> $stable(hold_r))
    else $error("holding register changed without a sync fall");

  latch_second_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    sync_fall ##1 (por_l_r && !mute_r && mode_r == sdip_pkg::MODE_OFF)
      |=> dac_code == $past(hold_r))
    else $error("latch not loaded on second edge after sync fall");

  bypass_load_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    sync_fall ##1 (por_l_r && !mute_r && mode_r == sdip_pkg::MODE_BYPASS)
      |=> dac_code == $past(hold_r))
    else $error("bypass did not load the latch from holding register");

  mute_mid_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    sync_fall ##1 mute_r |=> dac_code == sdip_pkg::CODE_MID)
    else $error("mute did not force mid-scale");

  latch_keep_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    $changed(dac_code) |-> $past(xf_state_r) == sdip_pkg::XF_PEND || !$past(por_l_r))
    else $error("latch changed outside a transfer edge");

  por_mid_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    !por_l_r |=> dac_code == sdip_pkg::CODE_MID)
    else $error("latch left mid-scale before power-on settled");

  por_time_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(por_done_r) |-> $past(por_cnt_r) == sdip_pkg::POR_CYCLES - 1'b1)
    else $error("power-on delay has the wrong length");

  filter_feed_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    xfer_now && mode_r != sdip_pkg::MODE_OFF
      |=> req_tgl_r != $past(req_tgl_r) || overrun_r)
    else $error("filtered word neither sent nor flagged");

  interp_hold_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    sync_fall ##1 (por_l_r && !mute_r && mode_r == sdip_pkg::MODE_INTERP) |=> $stable(dac_code))
    else $error("latch changed while the filter drives the output");

  off_no_feed_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    xfer_now && mode_r == sdip_pkg::MODE_OFF |=> req_tgl_r == $past(req_tgl_r))
    else $error("word sent to the filter while it is disabled");

  overrun_keep_a: assert property (@(posedge link_clk) disable iff (lrst_r)
    overrun_r |=> overrun_r)
    else $error("overrun flag cleared without reset");

  buf_stall_a: assert property (@(posedge clk_sys) disable iff (srst)
    filt_valid && !filt_ready |=> filt_valid && $stable(filt_word))
    else $error("filter word changed while stalled");

endmodule

// file: verif/sdip_host_model.sv
// Host model that drives the bit clock, serial data and word sync of the link.
`timescale 1ns/1ps
module sdip_host_model #(
  parameter int HALF_NS = 24
) (
  output logic link_clk,
  output logic serial_data_in,
  output logic word_sync
);
  // ****
  // Word queues
  // ****
  // Words to send, and the last sixteen bits seen on the wire at each frame start.
  logic [15:0] tx_q[$];
  logic [15:0] exp_q[$];
  logic [15:0] cur_r;
  logic [15:0] hist_r = 16'h0000;
  int bits_left = 0;

  initial begin
    link_clk = 1'b0;
    serial_data_in = 1'b0;
    word_sync = 1'b1;
  end

  // The bit clock runs free, since the filter needs it between words.
  always #(HALF_NS) link_clk = ~link_clk;

  // Bits change on the falling edge, away from the sampling edge.
  // Idle bits toggle so that a stale bit is never mistaken for a held one.
  always @(negedge link_clk) begin
    if (bits_left == 0 && tx_q.size() > 0) begin
      cur_r = tx_q.pop_front();
      exp_q.push_back(hist_r);
      word_sync <= 1'b0;
      serial_data_in <= cur_r[15];
      hist_r = {hist_r[14:0], cur_r[15]};
      bits_left = 15;
    end else if (bits_left > 0) begin
      word_sync <= 1'b1;
      serial_data_in <= cur_r[bits_left-1];
      hist_r = {hist_r[14:0], cur_r[bits_left-1]};
      bits_left--;
    end else begin
      word_sync <= 1'b1;
      serial_data_in <= ~serial_data_in;
      hist_r = {hist_r[14:0], ~serial_data_in};
    end
  end
endmodule

// file: verif/sdip_top_tb.sv
// Self-checking bench of the serial converter input port.
`timescale 1ns/1ps
module sdip_top_tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic filter_bypass_n = 1'b1;
  logic output_mute_n = 1'b1;
  logic filter_reset_n = 1'b0;
  logic [1:0] osr_sel = 2'h0;
  logic [1:0] nosr;
  logic filt_ready = 1'b0;
  logic stall = 1'b0;
  logic link_clk;
  logic serial_data_in;
  logic word_sync;
  logic [15:0] dac_code;
  sdip_pkg::sdip_mode_e filter_mode;
  sdip_pkg::sdip_mode_e m_exp;
  logic overrun;
  logic por_done;
  logic filt_valid;
  sdip_pkg::sdip_word_s filt_word;
  logic [31:0] seed = 32'had337aa6;
  logic [15:0] exp_code = sdip_pkg::CODE_MID;
  logic [15:0] cap;
  logic [17:0] fq[$];
  logic ws_prev = 1'b1;
  logic fall = 1'b0;
  logic fall_d = 1'b0;
  int errors = 0;
  int checked = 0;
  logic [15:0] corners[5] = '{sdip_pkg::CODE_POS_FULL, sdip_pkg::CODE_NEG_FULL, sdip_pkg::CODE_MID, 16'hffff, 16'h0001};

  always #12.5 clk_sys = ~clk_sys;

  sdip_top u_sdip_top (.clk_sys(clk_sys), .srst(srst), .link_clk(link_clk), .serial_data_in(serial_data_in),
    .word_sync(word_sync), .filter_bypass_n(filter_bypass_n), .output_mute_n(output_mute_n),
    .filter_reset_n(filter_reset_n), .osr_sel(osr_sel), .filt_ready(filt_ready), .dac_code(dac_code),
    .filter_mode(filter_mode), .overrun(overrun), .por_done(por_done), .filt_valid(filt_valid),
    .filt_word(filt_word));

  sdip_host_model u_sdip_host_model (.link_clk(link_clk), .serial_data_in(serial_data_in), .word_sync(word_sync));

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Reset pin wins over bypass; both pins are active low.
  function automatic sdip_pkg::sdip_mode_e mode_of(input logic frst_n, input logic byp_n);
    if (!frst_n) return sdip_pkg::MODE_OFF;
    if (!byp_n) return sdip_pkg::MODE_BYPASS;
    return sdip_pkg::MODE_INTERP;
  endfunction

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Queues one word per link cycle so frames follow back to back, then lets the link idle.
  task automatic burst(input int n, input logic use_corners);
    repeat (8) @(posedge link_clk);
    for (int i = 0; i < n; i++) begin
      @(posedge link_clk);
      u_sdip_host_model.tx_q.push_back((use_corners && i < 5) ? corners[i] : seed[15:0]);
    end
    for (int t = 0; t < 4000 && u_sdip_host_model.tx_q.size() != 0; t++) @(posedge link_clk);
    // A host queue that never drains is a hang, so it counts as a mismatch.
    chk("host queue drained", 18'h0, 18'(u_sdip_host_model.tx_q.size()));
    repeat (40) @(posedge link_clk);
    // Leave on a falling edge so link-domain outputs are settled when looked at.
    @(negedge link_clk);
  endtask

  // ****
  // Monitors
  // ****
  // The latch must hold at the sync-fall edge and one edge later take the word, or mid-scale if muted; unmuted interpolation keeps it.
  always @(posedge link_clk) begin
    fall = ws_prev & ~word_sync;
    ws_prev = word_sync;
    #1;
    if (fall_d) chk("dac_code after transfer", exp_code, dac_code);
    fall_d = fall;
    if (fall && u_sdip_host_model.exp_q.size() > 0) begin
      cap = u_sdip_host_model.exp_q.pop_front();
      m_exp = mode_of(filter_reset_n, filter_bypass_n);
      chk("dac_code at sync fall", exp_code, dac_code);
      chk("filter_mode", m_exp, filter_mode);
      if (!output_mute_n) exp_code = sdip_pkg::CODE_MID;
      else if (m_exp != sdip_pkg::MODE_INTERP) exp_code = cap;
      if (m_exp != sdip_pkg::MODE_OFF) fq.push_back({cap, osr_sel});
    end
  end

  // Words leave the buffer in order, each once.
  always @(posedge clk_sys) begin
    if (!srst && filt_valid === 1'b1 && filt_ready === 1'b1) begin
      if (fq.size() == 0) chk("filter word unexpected", 18'h0, 18'h1);
      else chk("filt_word", fq.pop_front(), filt_word);
    end
  end

  // Random stalls by the filter side; a forced stall fills the buffer.
  always @(negedge clk_sys) begin
    seed <= xs(seed);
    filt_ready <= ~stall & (seed[0] | seed[1]);
  end

  initial begin
    #400000;
    errors++;
    report_and_stop();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (16) @(negedge clk_sys);
    chk("dac_code in reset", sdip_pkg::CODE_MID, dac_code);
    srst = 1'b0;
    repeat (1195) @(negedge clk_sys);
    chk("por_done early", 18'h0, por_done);
    repeat (10) @(negedge clk_sys);
    chk("por_done", 18'h1, por_done);
    repeat (8) @(negedge link_clk);
    chk("dac_code after power-on", sdip_pkg::CODE_MID, dac_code);
    for (int m = 0; m < 3; m++) begin
      @(posedge link_clk);
      nosr = seed[3:2];
      @(negedge clk_sys);
      filter_reset_n = (m != 0);
      filter_bypass_n = (m != 1);
      osr_sel = nosr;
      burst(11, 1'b1);
    end
    @(negedge clk_sys);
    filter_reset_n = 1'b0;
    output_mute_n = 1'b0;
    burst(4, 1'b0);
    @(negedge clk_sys);
    output_mute_n = 1'b1;
    filter_reset_n = 1'b1;
    filter_bypass_n = 1'b0;
    burst(2, 1'b0);
    chk("overrun idle", 18'h0, overrun);
    stall = 1'b1;
    burst(5, 1'b0);
    chk("overrun", 18'h1, overrun);
    // Two words sit in the buffer and one waits; later ones are dropped.
    while (fq.size() > 3) void'(fq.pop_back());
    stall = 1'b0;
    repeat (200) @(negedge clk_sys);
    chk("filter words left", 18'h0, 18'(fq.size()));
    report_and_stop();
  end
endmodule
